//--- card_socket_model.sv
// Card socket model: answers the 16-bit I/O indication of an inserted card.
// Assumes the bench feeds it the host cycle lines and the system clock.
`timescale 1ns/10ps
module card_socket_model (
    // Host cycle seen at the socket
    input  wire logic        i_sys_clk,
    input  wire logic        i_cyc_strobe,
    input  wire logic        i_cyc_io,
    input  wire logic [23:0] i_cyc_addr,
    // Card status
    output logic             o_card_iois16_n
);
    logic toggle = 1'b0;
    always @(posedge i_sys_clk) toggle <= ~toggle;
    // Undriven outside I/O cycles, so show a moving level
    assign o_card_iois16_n = (i_cyc_strobe && i_cyc_io) ? ~i_cyc_addr[3] : toggle;
endmodule

//--- card_socket_window_decoder.sv
// Window decoder for a host bus to PC Card controller, one or two sockets.
// Assumes host cycles arrive already decoded as single-cycle strobes on i_sys_clk
// and that software programs the windows over AXI4-Lite.
// Strap state is cleared by power good going low, never by the reset input.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Overview of operation
// RQ1 - On power-good rising edge, latch socket-range select pin once and keep it.
// RQ2 - Select high: socket 0 at indexes 00h-3Fh, socket 1 at 40h-7Fh.
// RQ3 - Select low: socket 2 at indexes 80h-BFh, socket 3 at C0h-FFh.
// RQ4 - Each socket has five memory windows and two I/O windows.
// RQ5 - A disabled memory window never answers a host memory cycle.
// RQ6 - Memory start/end use 4-Kbyte pages, lowest 1000h, within 16 Mbyte; the code clamps to 10000h instead.
// RQ7 - Memory cycle claimed only when address lies between start and end.
// RQ8 - Card address equals host address plus the window offset.
// RQ9 - Memory windows use their programmed 8 or 16 bit width.
// RQ10 - Each window selects one of two timing sets.
// RQ11 - Memory window option drives the card attribute-memory select.
// RQ12 - Write-protected memory windows drop writes; reads go through.
// RQ13 - Each I/O window has its own enable checked before claiming.
// RQ14 - I/O start/end are byte-granular within 64 Kbytes.
// RQ15 - Auto-sized I/O windows take width from the card 16-bit indication.
// RQ16 - Manual I/O width overrides auto sizing.
// RQ17 - Software must keep windows from overlapping each other or other devices.
// RQ18 - I/O cycle claimed only when enabled and address within start and end.
// RQ19 - Index accesses outside the latched range are ignored.
module card_socket_window_decoder
    import csw_pkg::*;
#(
    parameter int NUM_SOCK = 2
) (
    // Clock and reset
    input  wire logic                i_sys_clk,
    input  wire logic                i_sys_rst,
    // Power-on strap
    input  wire logic                i_power_good_in,
    input  wire logic                i_socket_range_select_pin,
    // AXI4-Lite slave
    input  wire logic [11:0]         i_s_axi_awaddr,
    input  wire logic                i_s_axi_awvalid,
    output logic                     o_s_axi_awready,
    input  wire logic [31:0]         i_s_axi_wdata,
    input  wire logic [3:0]          i_s_axi_wstrb,
    input  wire logic                i_s_axi_wvalid,
    output logic                     o_s_axi_wready,
    output logic [1:0]               o_s_axi_bresp,
    output logic                     o_s_axi_bvalid,
    input  wire logic                i_s_axi_bready,
    input  wire logic [11:0]         i_s_axi_araddr,
    input  wire logic                i_s_axi_arvalid,
    output logic                     o_s_axi_arready,
    output logic [31:0]              o_s_axi_rdata,
    output logic [1:0]               o_s_axi_rresp,
    output logic                     o_s_axi_rvalid,
    input  wire logic                i_s_axi_rready,
    // Index port access check
    input  wire logic [7:0]          i_index,
    output logic                     o_index_hit,
    output logic                     o_index_sock,
    // Host cycle
    input  wire logic                i_cyc_strobe,
    input  wire logic                i_cyc_io,
    input  wire logic                i_cyc_write,
    input  wire logic [HADDR_W-1:0]  i_cyc_addr,
    input  wire logic                i_card_iois16_n,
    // Decode result
    output logic                     o_claim,
    output logic                     o_claim_sock,
    output logic [HADDR_W-1:0]       o_card_addr,
    output logic                     o_card_w16,
    output logic                     o_card_tset,
    output logic                     o_card_reg_n,
    output logic                     o_card_write_en
);
    // ********************************
    // Types
    // ********************************
    typedef struct packed {
        logic [6:0]          ctrl;
        logic [HADDR_W-1:0]  start;
        logic [HADDR_W-1:0]  stop;
        logic [HADDR_W-1:0]  offs;
    } win_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRSP = 3'b010,
        BUS_RRSP = 3'b100
    } bus_state_t;

    typedef struct packed {
        logic [2:0]          pg_sync;
        logic [2:0]          sel_sync;
        logic                pg_seen;
        logic                range_sel;
        logic                aw_got;
        logic                w_got;
        logic [11:0]         awaddr;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        bus_state_t          wst;
        bus_state_t          rst;
        logic [1:0]          bresp;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        win_t [NUM_SOCK-1:0][NUM_MEM_WIN+NUM_IO_WIN-1:0] win;
        logic                claim;
        logic                claim_sock;
        logic [HADDR_W-1:0]  card_addr;
        logic                w16;
        logic                tset;
        logic                reg_n;
        logic                wr_en;
    } state_t;

    state_t st;
    state_t next_st;

    // ********************************
    // Register address decode
    // ********************************
    function automatic logic dec(input logic [11:0] a, output int s, output int w,
                                 output logic [3:0] f);
        logic [7:0] lo;
        lo = a[7:0];
        s = int'(a[11:8]) - 1;
        f = lo[3:0];
        if (lo >= 8'(OFF_IO_BASE))
            w = NUM_MEM_WIN + int'((lo - 8'(OFF_IO_BASE)) >> 4);
        else
            w = int'(lo >> 4);
        return (a >= OFF_SOCK_STR) && (s < NUM_SOCK) && (a[1:0] == 2'b00)
            && (lo >= 8'(OFF_IO_BASE) ? w < NUM_MEM_WIN + NUM_IO_WIN : w < NUM_MEM_WIN);
    endfunction

    always_comb begin
        int          s;
        int          w;
        int          k;
        logic [3:0]  f;
        logic        ok;
        logic        hit;
        logic        in_rng;
        logic [HADDR_W-1:0] a;
        win_t        cw;
        s = 0;
        w = 0;
        k = 0;
        f = 4'h0;
        ok = 1'b0;
        hit = 1'b0;
        in_rng = 1'b0;
        a = '0;
        cw = '0;
        next_st = st;

        // ********************************
        // AXI4-Lite write
        // ********************************
        if (i_s_axi_awvalid && !st.aw_got && st.wst == BUS_IDLE) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && !st.w_got && st.wst == BUS_IDLE) begin
            next_st.w_got = 1'b1;
            next_st.wdata = i_s_axi_wdata;
            next_st.wstrb = i_s_axi_wstrb;
        end
        unique case (st.wst)
            BUS_IDLE: begin
                if (st.aw_got && st.w_got) begin
                    ok = dec(st.awaddr, s, w, f);
                    next_st.bresp = ok ? RESP_OKAY : RESP_SLVERR;
                    // Strobes latched with the data; any set strobe writes the word
                    if (ok && st.wstrb != 4'h0) begin
                        cw = st.win[s][w];
                        unique case (f)
                            OFF_W_CTRL:  cw.ctrl = st.wdata[6:0];
                            OFF_W_START: cw.start = {st.wdata[HADDR_W-1:PAGE_LSB],
                                                     {PAGE_LSB{1'b0}}};
                            OFF_W_END:   cw.stop = {st.wdata[HADDR_W-1:PAGE_LSB],
                                                    {PAGE_LSB{1'b1}}};
                            default:     cw.offs = st.wdata[HADDR_W-1:0];
                        endcase
                        if (w >= NUM_MEM_WIN) begin
                            // I/O windows are byte granular in 64K space
                            cw.start[HADDR_W-1:IOADDR_W] = '0; // RQ14
                            cw.stop[HADDR_W-1:IOADDR_W]  = '0; // RQ14
                            if (f == OFF_W_START)
                                cw.start[PAGE_LSB-1:0] = st.wdata[PAGE_LSB-1:0]; // RQ14
                            if (f == OFF_W_END)
                                cw.stop[PAGE_LSB-1:0] = st.wdata[PAGE_LSB-1:0]; // RQ14
                        end else begin
                            // Lowest page is 10000h; clamp rather than reject
                            if (cw.start[HADDR_W-1:PAGE_LSB] < MEM_PAGE_MIN)
                                cw.start[HADDR_W-1:PAGE_LSB] = MEM_PAGE_MIN; // RQ6
                            if (cw.stop[HADDR_W-1:PAGE_LSB] < MEM_PAGE_MIN)
                                cw.stop[HADDR_W-1:PAGE_LSB] = MEM_PAGE_MIN; // RQ6
                        end
                        next_st.win[s][w] = cw;
                    end
                    next_st.aw_got = 1'b0;
                    next_st.w_got  = 1'b0;
                    next_st.wst    = BUS_WRSP;
                end
            end
            BUS_WRSP: if (i_s_axi_bready) next_st.wst = BUS_IDLE;
            default:  next_st.wst = BUS_IDLE;
        endcase

        // ********************************
        // AXI4-Lite read
        // ********************************
        unique case (st.rst)
            BUS_IDLE: begin
                if (i_s_axi_arvalid) begin
                    next_st.rresp = RESP_OKAY;
                    next_st.rdata = '0;
                    if (i_s_axi_araddr == OFF_STATUS) begin
                        next_st.rdata = {30'h0, st.range_sel, st.pg_seen};
                    end else if (dec(i_s_axi_araddr, s, w, f)) begin
                        cw = st.win[s][w];
                        unique case (f)
                            OFF_W_CTRL:  next_st.rdata = 32'(cw.ctrl);
                            OFF_W_START: next_st.rdata = 32'(cw.start);
                            OFF_W_END:   next_st.rdata = 32'(cw.stop);
                            default:     next_st.rdata = 32'(cw.offs);
                        endcase
                    end else begin
                        next_st.rresp = RESP_SLVERR;
                    end
                    next_st.rst = BUS_RRSP;
                end
            end
            BUS_RRSP: if (i_s_axi_rready) next_st.rst = BUS_IDLE;
            default:  next_st.rst = BUS_IDLE;
        endcase

        // ********************************
        // Host cycle decode
        // ********************************
        // Overlap is software's problem; lowest socket, then lowest window in it, wins here
        next_st.claim = 1'b0; // RQ17
        if (i_cyc_strobe) begin
            for (int si = 0; si < NUM_SOCK; si++) begin
                for (int wi = 0; wi < NUM_MEM_WIN + NUM_IO_WIN; wi++) begin // RQ4
                    cw = st.win[si][wi];
                    a = i_cyc_io ? {{(HADDR_W-IOADDR_W){1'b0}}, i_cyc_addr[IOADDR_W-1:0]}
                                 : i_cyc_addr;
                    in_rng = (a >= cw.start) && (a <= cw.stop); // RQ7 RQ18
                    if (!hit && cw.ctrl[CB_EN] && in_rng // RQ5 RQ13
                        && (i_cyc_io == (wi >= NUM_MEM_WIN))) begin
                        hit = 1'b1;
                        next_st.claim      = 1'b1;
                        next_st.claim_sock = 1'(si);
                        next_st.card_addr  = a + cw.offs; // RQ8
                        next_st.tset       = cw.ctrl[CB_TSET]; // RQ10
                        if (wi < NUM_MEM_WIN) begin
                            next_st.w16   = cw.ctrl[CB_W16]; // RQ9
                            next_st.reg_n = ~cw.ctrl[CB_REG]; // RQ11
                            // Claimed reads keep write enable high; protected writes drop it
                            next_st.wr_en = !(i_cyc_write && cw.ctrl[CB_WP]); // RQ12
                        end else begin
                            next_st.reg_n = 1'b1;
                            // I/O windows carry no write protect
                            next_st.wr_en = 1'b1;
                            if (cw.ctrl[CB_MANUAL] || !cw.ctrl[CB_AUTO])
                                next_st.w16 = cw.ctrl[CB_W16]; // RQ16
                            else
                                next_st.w16 = ~i_card_iois16_n; // RQ15
                        end
                    end
                end
            end
        end
        k = hit ? 1 : 0;
        if (k == 0) begin
            next_st.wr_en = 1'b0;
            next_st.reg_n = 1'b1;
        end

        if (i_sys_rst) begin
            next_st = '0;
            next_st.wst   = BUS_IDLE;
            next_st.rst   = BUS_IDLE;
            next_st.reg_n = 1'b1;
            // Strap survives reset; only power good going low clears it
            next_st.pg_seen   = st.pg_seen;
            next_st.range_sel = st.range_sel;
        end

        // ********************************
        // Power-on strap
        // ********************************
        // Synchronisers run through reset so its release makes no false edge
        next_st.pg_sync  = {st.pg_sync[1:0], i_power_good_in};
        next_st.sel_sync = {st.sel_sync[1:0], i_socket_range_select_pin};
        // Power good settled low re-arms the latch for the next power-up
        if (st.pg_sync[2:1] == 2'b00) begin
            next_st.pg_seen   = 1'b0;
            next_st.range_sel = 1'b0;
        end else if (!st.pg_seen && st.pg_sync[2:1] == 2'b11
                     && st.sel_sync[2] == st.sel_sync[1]) begin
            // Once per power-up; later select pin moves are ignored
            next_st.pg_seen   = 1'b1; // RQ1
            next_st.range_sel = st.sel_sync[2]; // RQ1
        end
    end

    always_ff @(posedge i_sys_clk) begin
        st <= next_st;
    end

    // ********************************
    // Index range check
    // ********************************
    always_comb begin
        logic [1:0] base;
        base = st.range_sel ? IDX_SOCK_HI_SEL : IDX_SOCK_LO_SEL; // RQ2 RQ3
        o_index_sock = i_index[6];
        o_index_hit  = st.pg_seen && (i_index[7:6] - base) < 2'(NUM_SOCK)
                       && i_index[7] == base[1]; // RQ19
    end

    // ********************************
    // Outputs
    // ********************************
    assign o_s_axi_awready = !st.aw_got && st.wst == BUS_IDLE;
    assign o_s_axi_wready  = !st.w_got && st.wst == BUS_IDLE;
    assign o_s_axi_bvalid  = st.wst == BUS_WRSP;
    assign o_s_axi_bresp   = st.bresp;
    assign o_s_axi_arready = st.rst == BUS_IDLE;
    assign o_s_axi_rvalid  = st.rst == BUS_RRSP;
    assign o_s_axi_rdata   = st.rdata;
    assign o_s_axi_rresp   = st.rresp;
    assign o_claim         = st.claim;
    assign o_claim_sock    = st.claim_sock;
    assign o_card_addr     = st.card_addr;
    assign o_card_w16      = st.w16;
    assign o_card_tset     = st.tset;
    assign o_card_reg_n    = st.reg_n;
    assign o_card_write_en = st.wr_en;
endmodule

//--- card_socket_window_decoder_chk.sv
// Port checker for the window decoder.
// Assumes it is bound to every decoder instance.
`timescale 1ns/10ps
module card_socket_window_decoder_chk
    import csw_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_sys_rst,
    input wire logic [7:0]  i_index,
    input wire logic        o_index_sock,
    input wire logic        i_cyc_strobe,
    input wire logic        i_cyc_write,
    input wire logic        o_claim,
    input wire logic        o_card_write_en,
    input wire logic        o_s_axi_awready,
    input wire logic        o_s_axi_wready,
    input wire logic        o_s_axi_bvalid,
    input wire logic        i_s_axi_bready,
    input wire logic [1:0]  o_s_axi_bresp,
    input wire logic        i_s_axi_arvalid,
    input wire logic        o_s_axi_arready,
    input wire logic        o_s_axi_rvalid,
    input wire logic        i_s_axi_rready
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // ********
    // Decode
    // ********
    a_claim_after_strobe: assert property (o_claim |-> $past(i_cyc_strobe))
        else $error("claim without a host cycle");
    a_quiet_no_strobe: assert property (!i_cyc_strobe |=> !o_claim && !o_card_write_en)
        else $error("decode output without a host cycle");
    a_wen_needs_claim: assert property (o_card_write_en |-> o_claim)
        else $error("card write enable without a claim");
    a_read_goes_through: assert property (o_claim && !$past(i_cyc_write) |-> o_card_write_en)
        else $error("claimed read blocked");
    a_index_socket: assert property (o_index_sock == i_index[6])
        else $error("index socket bit wrong");
    // ********
    // Register bus
    // ********
    a_bresp_stands: assert property (o_s_axi_bvalid && !i_s_axi_bready
        |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response dropped");
    a_write_busy: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("write taken during response");
    a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read answer late");
    a_rvalid_stands: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid)
        else $error("read data dropped");
    c_claim_write: cover property (o_claim && o_card_write_en);
    c_bus_error: cover property (o_s_axi_bvalid && o_s_axi_bresp == RESP_SLVERR);
    c_read_stall: cover property (o_s_axi_rvalid && !i_s_axi_rready);
endmodule
bind card_socket_window_decoder card_socket_window_decoder_chk u_chk (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_index(i_index),
    .o_index_sock(o_index_sock), .i_cyc_strobe(i_cyc_strobe), .i_cyc_write(i_cyc_write),
    .o_claim(o_claim), .o_card_write_en(o_card_write_en), .o_s_axi_awready(o_s_axi_awready),
    .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready), .o_s_axi_bresp(o_s_axi_bresp),
    .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
    .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready));

//--- card_socket_window_decoder_tb.sv
// Bench for the window decoder: strap, index range, windows, register bus.
// Assumes the card model beside it and one 100 MHz clock.
`timescale 1ns/10ps
module card_socket_window_decoder_tb import csw_pkg::*; ;
    logic        clk = 0, rst = 1, pg = 0, sel = 1, strobe = 0, cio = 0, cwr = 0, pend = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, hit, isock, iois_n;
    logic        claim, csock, w16, tset, reg_n, wen;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0]  wstrb = 0;
    logic [1:0]  bresp, rresp;
    logic [7:0]  index = 0;
    logic [23:0] caddr = 0, card_addr;
    logic [31:0] cfg [2][7][4] = '{default: '0};
    logic [30:0] notes [$];
    int          error_cnt = 0, n_checks = 0;
    card_socket_window_decoder dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_power_good_in(pg),
        .i_socket_range_select_pin(sel), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
        .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
        .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
        .i_index(index), .o_index_hit(hit), .o_index_sock(isock), .i_cyc_strobe(strobe),
        .i_cyc_io(cio), .i_cyc_write(cwr), .i_cyc_addr(caddr), .i_card_iois16_n(iois_n),
        .o_claim(claim), .o_claim_sock(csock), .o_card_addr(card_addr), .o_card_w16(w16),
        .o_card_tset(tset), .o_card_reg_n(reg_n), .o_card_write_en(wen));
    card_socket_model card (.i_sys_clk(clk), .i_cyc_strobe(strobe), .i_cyc_io(cio),
        .i_cyc_addr(caddr), .o_card_iois16_n(iois_n));
    initial forever #5 clk = ~clk;
    // ********
    // Tasks
    // ********
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axi_wr(logic [11:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1;
        end
        bready <= 0;
        chk("bresp", er, bresp);
        if (er == RESP_OKAY && s != 0) cfg[a[9]][a[7] ? 5 + a[4] : a[6:4]][a[3:2]] = d;
    endtask
    task automatic axi_rd(logic [11:0] a, logic [31:0] ed, logic [1:0] er);
        araddr <= a;
        arvalid <= 1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1;
        end
        rready <= 0;
        chk("rresp", er, rresp);
        chk("rdata", ed, rdata);
    endtask
    function automatic logic [30:0] expect_of(logic io, logic wr, logic [23:0] a);
        logic [31:0] c;
        logic [11:0] lo;
        for (int s = 0; s < 2; s++)
            for (int n = 0; n < 7; n++) begin
                c = cfg[s][n][0];
                lo = cfg[s][n][1][23:12] < MEM_PAGE_MIN ? MEM_PAGE_MIN : cfg[s][n][1][23:12];
                if (c[0] && !io && n < 5 && a[23:12] >= lo && a[23:12] <= cfg[s][n][2][23:12])
                    return {2'b01, s[0], c[1], c[2], ~c[3], ~(wr & c[4]), a + cfg[s][n][3][23:0]};
                if (c[0] && io && n > 4 && a[15:0] >= cfg[s][n][1][15:0]
                    && a[15:0] <= cfg[s][n][2][15:0])
                    return {2'b11, s[0], c[6] ? c[1] : a[3], c[2], 1'b1, 1'b1,
                        {8'h0, a[15:0]} + cfg[s][n][3][23:0]};
            end
        return {io, 30'h0};
    endfunction
    task automatic host(logic io, logic wr, logic [23:0] a);
        strobe <= 1;
        cio <= io;
        cwr <= wr;
        caddr <= a;
        notes.push_back(expect_of(io, wr, a));
        @(posedge clk);
    endtask
    task automatic setup(int r);
        logic [31:0] c, v;
        logic [23:0] st, en, lo, hi, pts [5];
        logic [11:0] a, page;
        for (int k = 0; k < 14; k++) begin
            c = $urandom & 32'h7f;
            v = $urandom;
            if (r == 0) c[0] = 1'b1;
            if (!c[5]) c[6] = 1'b1;
            a = 12'(256 * (k / 7 + 1) + (k % 7 < 5 ? 16 * (k % 7) : 128 + 16 * (k % 7 - 5)));
            page = 12'h010 + 12'h020 * 12'(k);
            st = a[7] ? 24'h000400 * 24'(k) + 24'h10 : (k == 0 ? 24'h0 : {page, 12'h000});
            en = a[7] ? st + 24'hff : {page + 12'h00f, 12'h000};
            axi_wr(a, c, 4'hf, RESP_OKAY);
            axi_wr(a + 12'h4, {8'h0, st}, 4'hf, RESP_OKAY);
            axi_wr(a + 12'h8, {8'h0, en}, 4'hf, RESP_OKAY);
            axi_wr(a + 12'hc, {8'h0, v[11:0], 12'h000}, 4'hf, RESP_OKAY);
            axi_wr(a, ~c, 4'h0, RESP_OKAY);
            lo = a[7] ? st : {page, 12'h000};
            hi = a[7] ? en : {page + 12'h00f, 12'hfff};
            pts = '{lo - 24'h1, lo, hi, hi + 24'h1, lo + v[23:0] % (hi - lo + 24'h1)};
            foreach (pts[i]) begin
                host(a[7], 1'b0, pts[i]);
                host(a[7], 1'b1, pts[i]);
            end
            strobe <= 0;
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ********
    // Result monitor
    // ********
    always @(posedge clk) begin
        logic [30:0] e;
        if (pend) begin
            e = notes.pop_front();
            chk("claim", e[29], claim);
            chk("write_en", e[24], wen);
            if (e[29]) begin
                chk("claim_sock", e[28], csock);
                chk("card_addr", e[23:0], card_addr);
                chk("width16", e[27], w16);
                chk("timing_set", e[26], tset);
                if (!e[30]) chk("reg_n", e[25], reg_n);
            end
        end
        pend <= strobe && !rst;
    end
    initial begin
        void'($urandom(17));
        repeat (3) @(posedge clk);
        rst <= 0;
        pg <= 1;
        repeat (8) @(posedge clk);
        sel <= 0;
        repeat (8) @(posedge clk);
        // Second pass: power good cycled with the select pin low
        for (int p = 0; p < 2; p++) begin
            axi_rd(OFF_STATUS, p ? 32'h1 : 32'h3, RESP_OKAY);
            for (int i = 0; i < 256; i++) begin
                index <= 8'(i);
                @(posedge clk);
                chk("index_hit", p ? i >= 128 : i < 128, hit);
                chk("index_sock", i % 128 > 63, isock);
            end
            pg <= 0;
            repeat (8) @(posedge clk);
            pg <= 1;
            repeat (8) @(posedge clk);
        end
        axi_rd(12'h300, 32'h0, RESP_SLVERR);
        axi_rd(12'h150, 32'h0, RESP_SLVERR);
        axi_wr(12'h102, 32'h1, 4'hf, RESP_SLVERR);
        for (int r = 0; r < 3; r++) setup(r);
        repeat (3) @(posedge clk);
        summarize();
    end
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end
endmodule

//--- csw_pkg.sv
// Constants for the card socket window decoder.
// Assumes one 100 MHz system clock and an AXI4-Lite register port.
package csw_pkg;
    // ********************************
    // Geometry
    // ********************************
    localparam int NUM_MEM_WIN = 5;
    localparam int NUM_IO_WIN  = 2;
    localparam int HADDR_W     = 24;
    localparam int IOADDR_W    = 16;
    localparam int PAGE_LSB    = 12;
    localparam logic [11:0] MEM_PAGE_MIN = 12'h010;
    // ********************************
    // Index ranges
    // ********************************
    localparam logic [1:0] IDX_SOCK_HI_SEL = 2'h0;
    localparam logic [1:0] IDX_SOCK_LO_SEL = 2'h2;
    // ********************************
    // Register map, byte addresses
    // Per socket 0x100 block; memory window n at 0x10*n, I/O window at 0x80+0x10*n
    // ********************************
    localparam logic [11:0] OFF_STATUS   = 12'h000;
    localparam logic [11:0] OFF_SOCK_STR = 12'h100;
    localparam logic [11:0] OFF_MEM_BASE = 12'h000;
    localparam logic [11:0] OFF_IO_BASE  = 12'h080;
    localparam logic [3:0]  OFF_W_CTRL   = 4'h0;
    localparam logic [3:0]  OFF_W_START  = 4'h4;
    localparam logic [3:0]  OFF_W_END    = 4'h8;
    localparam logic [3:0]  OFF_W_OFFS   = 4'hc;
    // Window control bits
    localparam int CB_EN    = 0;
    localparam int CB_W16   = 1;
    localparam int CB_TSET  = 2;
    localparam int CB_REG   = 3;
    localparam int CB_WP    = 4;
    localparam int CB_AUTO  = 5;
    localparam int CB_MANUAL = 6;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
